/* rtl/swd_hwcmd.sv */
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_hwcmd
  import swd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic cmd_ready_out,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic ack_pulse_out,
  input wire logic fw_cmd_valid_in,
  input wire logic fw_cmd_leave_in,
  output logic fw_cmd_exec_out,
  input wire logic special_mode_in,
  input wire logic secured_in,
  input wire logic erase_check_done_in,
  input wire logic erase_ok_in,
  input wire logic cpu_halt_to_debug_instr_in,
  input wire logic ext_tag_in,
  input wire logic bkpt_in,
  input wire logic bkpt_after_next_in,
  input wire logic cpu_instr_done_in,
  output logic cpu_fw_start_out,
  output logic cpu_resume_out,
  input wire logic cpu_idle_in,
  output logic cpu_freeze_out,
  output logic bus_cyc_out,
  output logic [15:0] bus_addr_out,
  output logic bus_we_out,
  output logic [1:0] bus_be_out,
  output logic [15:0] bus_wdata_out,
  input wire logic [15:0] bus_rdata_in,
  input wire logic bus_done_in,
  output logic dbg_map_out,
  output logic fw_area_map_out,
  output logic debug_enable_flag_out,
  output logic unsecure_flag_out,
  output logic active_out
);
  localparam logic [2:0] RESUME_CYC = 3'(`SWD_RESUME_DLY_CYC);
  localparam logic [15:0] STATUS_ADDR = `SWD_STATUS_ADDR;

  // ========================================================================
  // Mode and security state.
  swd_cmd_state_t st_r;
  logic start_r;
  logic special_r;
  logic secured_r;
  logic enable_r;
  logic unsecure_flag_r;
  logic active_r;
  logic ack_en_r;
  logic halt_ack_pend_r;
  logic [1:0] entry_cnt_r;
  logic [2:0] resume_cnt_r;
  logic ack_r;
  logic fw_start_r;
  logic resume_r;
  logic [15:0] rd_data_r;
  logic rd_valid_r;

  // ========================================================================
  // Latched command.
  logic [15:0] addr_r;
  logic [15:0] wdata_r;
  logic word_r;
  logic we_r;
  logic bd_r;

  wire unsecured = ~secured_r | unsecure_flag_r;
  // Secured parts take hardware commands only in special mode once enabled or unsecured.
  wire hw_allowed = unsecured | (special_r & enable_r);
  wire accept = cmd_valid_in & (st_r == SWD_IDLE) & ~start_r;
  wire go = accept & hw_allowed;

  // ========================================================================
  // Opcode decode.
  wire op_halt = (cmd_opcode_in == `SWD_OP_HALT);
  wire op_ack_on = (cmd_opcode_in == `SWD_OP_ACK_ON);
  wire op_ack_off = (cmd_opcode_in == `SWD_OP_ACK_OFF);
  wire op_rd_bd = (cmd_opcode_in == `SWD_OP_RD_BD_BYTE) | (cmd_opcode_in == `SWD_OP_RD_BD_WORD);
  wire op_rd_mem = (cmd_opcode_in == `SWD_OP_RD_BYTE) | (cmd_opcode_in == `SWD_OP_RD_WORD);
  wire op_wr_bd = (cmd_opcode_in == `SWD_OP_WR_BD_BYTE) | (cmd_opcode_in == `SWD_OP_WR_BD_WORD);
  wire op_wr_mem = (cmd_opcode_in == `SWD_OP_WR_BYTE) | (cmd_opcode_in == `SWD_OP_WR_WORD);
  wire op_bus = op_rd_bd | op_rd_mem | op_wr_bd | op_wr_mem;
  wire op_word = cmd_opcode_in[3];
  wire op_we = ~cmd_opcode_in[5];
  wire op_bd = cmd_opcode_in[2];

  // ========================================================================
  // Activation.
  wire cpu_trig = cpu_halt_to_debug_instr_in | ext_tag_in | bkpt_in;
  wire idle_mode = ~active_r & (entry_cnt_r == 2'h0);
  wire halt_go = go & op_halt & enable_r;
  wire trig_go = idle_mode & enable_r & (halt_go | cpu_trig);
  wire trig_refused = ~enable_r & cpu_trig & (resume_cnt_r == 3'h0);
  // A breakpoint of the after type waits for one more instruction boundary.
  wire [1:0] entry_load = (bkpt_in & bkpt_after_next_in) ? 2'h2 : 2'h1;
  wire entry_reached = (entry_cnt_r == 2'h1) & cpu_instr_done_in;

  // ========================================================================
  // Bus access.
  wire bus_done;
  wire [15:0] rd_fmt;
  wire [15:0] lane_addr;
  wire status_hit = bd_r & (lane_addr[15:1] == STATUS_ADDR[15:1]) & (word_r | lane_addr[0]);
  wire [7:0] status_val = 8'((enable_r << `SWD_STATUS_ENABLE_BIT)
                            | (active_r << `SWD_STATUS_ACTIVE_BIT)
                            | (unsecure_flag_r << `SWD_STATUS_UNSECURE_FLAG_BIT));
  // Debug-unit reads of the status register see live state, never stale memory.
  wire [15:0] rd_final = status_hit ? {rd_fmt[15:8], status_val} : rd_fmt;
  wire status_wr = bus_done & we_r & status_hit;
  wire status_en_bit = wdata_r[`SWD_STATUS_ENABLE_BIT];

  swd_arb u_arb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .req_in(go & op_bus),
    .cpu_idle_in(cpu_idle_in),
    .bus_done_in(bus_done_in),
    .bus_cyc_out(bus_cyc_out),
    .freeze_out(cpu_freeze_out),
    .done_out(bus_done)
  );

  swd_lane u_lane (
    .addr_in(addr_r),
    .word_in(word_r),
    .rdata_in(bus_rdata_in),
    .addr_out(lane_addr),
    .be_out(bus_be_out),
    .rdata_out(rd_fmt)
  );

  assign bus_addr_out = lane_addr;
  assign bus_we_out = we_r;
  assign bus_wdata_out = wdata_r;
  // Debug resources appear only in the debug-space access cycle.
  assign dbg_map_out = bus_cyc_out & bd_r;
  // Memory commands run with the firmware area mapped out.
  assign fw_area_map_out = active_r & ~(bus_cyc_out & ~bd_r);
  assign cmd_ready_out = (st_r == SWD_IDLE) & ~start_r;
  assign fw_cmd_exec_out = fw_cmd_valid_in & unsecured & active_r;
  assign rd_data_out = rd_data_r;
  assign rd_valid_out = rd_valid_r;
  assign ack_pulse_out = ack_r;
  assign cpu_fw_start_out = fw_start_r;
  assign cpu_resume_out = resume_r;
  assign debug_enable_flag_out = enable_r;
  assign unsecure_flag_out = unsecure_flag_r;
  assign active_out = active_r;

  // ========================================================================
  // Command sequencing.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= SWD_IDLE;
      addr_r <= 16'h0000;
      wdata_r <= 16'h0000;
      word_r <= 1'b0;
      we_r <= 1'b0;
      bd_r <= 1'b0;
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      if (go & op_bus) begin
        st_r <= SWD_BUS;
        addr_r <= cmd_addr_in;
        wdata_r <= cmd_wdata_in;
        word_r <= op_word;
        we_r <= op_we;
        bd_r <= op_bd;
      end else if (bus_done) begin
        st_r <= SWD_IDLE;
        if (!we_r) begin
          rd_data_r <= rd_final;
          rd_valid_r <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // Handshake.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_en_r <= 1'b0;
      ack_r <= 1'b0;
      halt_ack_pend_r <= 1'b0;
    end else begin
      ack_r <= 1'b0;
      if (go & op_ack_on) begin
        ack_en_r <= 1'b1;
        ack_r <= 1'b1;
      end else if (go & op_ack_off) begin
        ack_en_r <= 1'b0;
      end else if (bus_done & ack_en_r) begin
        ack_r <= 1'b1;
      end else if (entry_reached & halt_ack_pend_r & ack_en_r) begin
        ack_r <= 1'b1;
      end
      // Unknown opcodes fall through every branch above.
      if (trig_go & halt_go) begin
        halt_ack_pend_r <= 1'b1;
      end else if (entry_reached) begin
        halt_ack_pend_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Security and activity flags.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_r <= 1'b1;
      special_r <= 1'b0;
      secured_r <= 1'b0;
      enable_r <= 1'b0;
      unsecure_flag_r <= 1'b0;
      active_r <= 1'b0;
      entry_cnt_r <= 2'h0;
      fw_start_r <= 1'b0;
    end else begin
      fw_start_r <= 1'b0;
      // Straps are caught in the first cycle after reset, not by the reset itself.
      if (start_r) begin
        start_r <= 1'b0;
        special_r <= special_mode_in;
        secured_r <= secured_in;
        if (special_mode_in) begin
          enable_r <= 1'b1;
          active_r <= 1'b1;
        end
      end else begin
        if (status_wr) begin
          enable_r <= status_en_bit;
        end
        // The erase result is applied after the status write so that it wins.
        if (erase_check_done_in & special_r & secured_r) begin
          enable_r <= 1'b1;
          if (erase_ok_in) begin
            unsecure_flag_r <= 1'b1;
          end
        end
        if (trig_go) begin
          entry_cnt_r <= entry_load;
        end else if (cpu_instr_done_in & (entry_cnt_r != 2'h0)) begin
          entry_cnt_r <= entry_cnt_r - 2'h1;
        end
        if (entry_reached) begin
          active_r <= 1'b1;
          fw_start_r <= 1'b1;
        end else if (fw_cmd_exec_out & fw_cmd_leave_in) begin
          active_r <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Refused activation: the CPU is released after a short delay.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      resume_cnt_r <= 3'h0;
      resume_r <= 1'b0;
    end else begin
      resume_r <= 1'b0;
      if (trig_refused) begin
        resume_cnt_r <= RESUME_CYC;
      end else if (resume_cnt_r != 3'h0) begin
        resume_cnt_r <= resume_cnt_r - 3'h1;
        if (resume_cnt_r == 3'h1) begin
          resume_r <= 1'b1;
        end
      end
    end
  end
endmodule

/* rtl/swd_params.svh */
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH

// ==========================================================================
// Opcodes of the hardware command class.
`define SWD_OP_HALT 8'h90
`define SWD_OP_ACK_ON 8'hd5
`define SWD_OP_ACK_OFF 8'hd6
`define SWD_OP_RD_BD_BYTE 8'he4
`define SWD_OP_RD_BD_WORD 8'hec
`define SWD_OP_RD_BYTE 8'he0
`define SWD_OP_RD_WORD 8'he8
`define SWD_OP_WR_BD_BYTE 8'hc4
`define SWD_OP_WR_BD_WORD 8'hcc
`define SWD_OP_WR_BYTE 8'hc0
`define SWD_OP_WR_WORD 8'hc8

// ==========================================================================
// Debug register window and the status register inside it.
`define SWD_DBG_GLOBAL_FIRST 24'h7fff00
`define SWD_DBG_GLOBAL_LAST 24'h7fff0b
`define SWD_STATUS_ADDR 16'hff01
`define SWD_STATUS_ENABLE_BIT 7
`define SWD_STATUS_ACTIVE_BIT 6
`define SWD_STATUS_UNSECURE_FLAG_BIT 1

// ==========================================================================
// Timing.
`define SWD_CLK_MHZ 25
`define SWD_STEAL_WAIT_CYC 128
`define SWD_RESUME_DLY_NS 160
`define SWD_RESUME_DLY_CYC ((`SWD_RESUME_DLY_NS * `SWD_CLK_MHZ + 999) / 1000)

`endif

/* rtl/swd_pkg.sv */
package swd_pkg;
  typedef enum logic [0:0] {SWD_IDLE, SWD_BUS} swd_cmd_state_t;
  typedef enum logic [1:0] {SWD_ARB_IDLE, SWD_ARB_WAIT, SWD_ARB_ACCESS} swd_arb_state_t;
endpackage

/* rtl/swd_lane.sv */
`timescale 1ns/1ps
module swd_lane
  import swd_pkg::*;
(
  input wire logic [15:0] addr_in,
  input wire logic word_in,
  input wire logic [15:0] rdata_in,
  output logic [15:0] addr_out,
  output logic [1:0] be_out,
  output logic [15:0] rdata_out
);
  wire odd = addr_in[0];
  wire [15:0] byte_rd = odd ? {8'h00, rdata_in[7:0]} : {rdata_in[15:8], 8'h00};

  // A misaligned word is taken at the even address below it.
  assign addr_out = word_in ? {addr_in[15:1], 1'b0} : addr_in;
  // Even address on the high lane, odd address on the low lane.
  assign be_out = word_in ? 2'h3 : (odd ? 2'h1 : 2'h2);
  // A byte read still returns sixteen bits with only one lane valid.
  assign rdata_out = word_in ? rdata_in : byte_rd;
endmodule

/* rtl/swd_arb.sv */
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_arb
  import swd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic cpu_idle_in,
  input wire logic bus_done_in,
  output logic bus_cyc_out,
  output logic freeze_out,
  output logic done_out
);
  localparam logic [6:0] LAST_WAIT = 7'(`SWD_STEAL_WAIT_CYC - 1);

  swd_arb_state_t st_r, st_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic stolen_r, stolen_nxt;
  logic first_r, first_nxt;

  wire in_access = (st_r == SWD_ARB_ACCESS);
  wire timeout = (cnt_r == LAST_WAIT);

  assign bus_cyc_out = in_access;
  assign done_out = in_access & bus_done_in;
  // A stolen cycle freezes the CPU; so does every cycle after the first.
  assign freeze_out = in_access & (stolen_r | ~first_r);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    stolen_nxt = stolen_r;
    first_nxt = 1'b0;
    unique case (st_r)
      SWD_ARB_IDLE: begin
        if (req_in) begin
          st_nxt = SWD_ARB_WAIT;
          cnt_nxt = 7'h00;
        end
      end
      SWD_ARB_WAIT: begin
        cnt_nxt = cnt_r + 7'h01;
        if (cpu_idle_in) begin
          st_nxt = SWD_ARB_ACCESS;
          stolen_nxt = 1'b0;
          first_nxt = 1'b1;
        end else if (timeout) begin
          st_nxt = SWD_ARB_ACCESS;
          stolen_nxt = 1'b1;
          first_nxt = 1'b1;
        end
      end
      SWD_ARB_ACCESS: begin
        if (bus_done_in) begin
          st_nxt = SWD_ARB_IDLE;
        end
      end
      default: st_nxt = SWD_ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= SWD_ARB_IDLE;
      cnt_r <= 7'h00;
      stolen_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      stolen_r <= stolen_nxt;
      first_r <= first_nxt;
    end
  end
endmodule

/* tb/swd_hwcmd_checker.sv */
`timescale 1ns/1ps
`include "swd_params.svh"
// ==========================================================================
// Port checker for the hardware command block.
module swd_hwcmd_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic cmd_ready_out,
  input wire logic rd_valid_out,
  input wire logic ack_pulse_out,
  input wire logic bus_done_in,
  input wire logic bus_cyc_out,
  input wire logic [1:0] bus_be_out,
  input wire logic [15:0] bus_addr_out,
  input wire logic fw_cmd_valid_in,
  input wire logic fw_cmd_exec_out,
  input wire logic secured_in,
  input wire logic special_mode_in,
  input wire logic unsecure_flag_out,
  input wire logic debug_enable_flag_out,
  input wire logic active_out,
  input wire logic cpu_halt_to_debug_instr_in,
  input wire logic cpu_resume_out,
  input wire logic erase_check_done_in,
  input wire logic erase_ok_in,
  input wire logic cpu_idle_in,
  input wire logic cpu_freeze_out,
  input wire logic cpu_fw_start_out,
  input wire logic dbg_map_out,
  input wire logic fw_area_map_out
);
  wire tk = cmd_valid_in & cmd_ready_out;
  wire ok = !secured_in | unsecure_flag_out | (special_mode_in & debug_enable_flag_out);
  wire mem = cmd_opcode_in[7:6] == 2'h3 && !cmd_opcode_in[4] && cmd_opcode_in[1:0] == 2'h0;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_fw;
    fw_cmd_exec_out == (fw_cmd_valid_in & (!secured_in | unsecure_flag_out) & active_out);
  endproperty
  a_fw: assert property (p_fw) else $error("firmware gating wrong");
  property p_steal; tk && mem && ok |-> ##[1:131] bus_cyc_out; endproperty
  a_steal: assert property (p_steal) else $error("no bus access in time");
  property p_rdy; rd_valid_out |-> $past(bus_done_in & bus_cyc_out); endproperty
  a_rdy: assert property (p_rdy) else $error("read data without bus end");
  property p_lane;
    bus_cyc_out |-> (bus_be_out == 2'h3 && !bus_addr_out[0]) ||
      bus_be_out == (bus_addr_out[0] ? 2'h1 : 2'h2);
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");
  property p_halt;
    tk && cmd_opcode_in == `SWD_OP_HALT && !debug_enable_flag_out |=> !active_out && !ack_pulse_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt acted while disabled");
  property p_ackon; tk && ok && cmd_opcode_in == `SWD_OP_ACK_ON |=> ack_pulse_out; endproperty
  a_ackon: assert property (p_ackon) else $error("no handshake pulse");
  property p_unk; tk && cmd_opcode_in == 8'h00 |=> (!bus_cyc_out && !ack_pulse_out) [*3]; endproperty
  a_unk: assert property (p_unk) else $error("unknown opcode acted");
  property p_ref; tk && !ok |=> (!bus_cyc_out && !rd_valid_out && !ack_pulse_out) [*4]; endproperty
  a_ref: assert property (p_ref) else $error("secured command acted");
  property p_res; cpu_halt_to_debug_instr_in && !debug_enable_flag_out |-> ##5 cpu_resume_out;
  endproperty
  a_res: assert property (p_res) else $error("cpu not resumed");
  property p_uns; $rose(unsecure_flag_out) |-> $past(erase_check_done_in && erase_ok_in); endproperty
  a_uns: assert property (p_uns) else $error("unsecure without erase");
  // The first access cycle is frozen only when it had to be stolen.
  property p_frz1;
    bus_cyc_out && !$past(bus_cyc_out) |-> cpu_freeze_out == !$past(cpu_idle_in);
  endproperty
  a_frz1: assert property (p_frz1) else $error("first access freeze wrong");
  property p_frz2;
    (bus_cyc_out && $past(bus_cyc_out) |-> cpu_freeze_out) and (cpu_freeze_out |-> bus_cyc_out);
  endproperty
  a_frz2: assert property (p_frz2) else $error("multi-cycle freeze wrong");
  property p_fws; cpu_fw_start_out |-> $rose(active_out); endproperty
  a_fws: assert property (p_fws) else $error("firmware start without entry");
  property p_map;
    (dbg_map_out |-> bus_cyc_out) and (bus_cyc_out && !dbg_map_out |-> !fw_area_map_out);
  endproperty
  a_map: assert property (p_map) else $error("debug map wrong");
  c_frz: cover property (cpu_freeze_out && bus_cyc_out);
  c_mem: cover property (tk && mem);
  c_res: cover property (cpu_resume_out);
  c_act: cover property ($rose(active_out));
endmodule

bind swd_hwcmd swd_hwcmd_checker i_swd_hwcmd_checker (.*);

/* tb/swd_mem_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Bus slave with a latency chosen by the bench.
module swd_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cyc_in,
  input wire logic map_in,
  input wire logic we_in,
  input wire logic [1:0] be_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [1:0] lat_in,
  output logic [15:0] rdata_out,
  output logic done_out
);
  logic [15:0] mem_r [0:127];
  logic [1:0] cnt_r;
  logic [15:0] last_r;
  wire [6:0] idx = {map_in, addr_in[6:1]};
  assign done_out = cyc_in && cnt_r == lat_in;
  // Off the answering cycle the lines show the inverse word, so early sampling shows up.
  assign rdata_out = done_out ? mem_r[idx] : ~last_r;
  always_ff @(posedge clk_in) begin
    cnt_r <= (done_out || !cyc_in) ? 2'h0 : cnt_r + 2'h1;
    last_r <= rst_in ? 16'h0000 : rdata_out;
    if (rst_in) begin
      for (int i = 0; i < 128; i++) mem_r[i] <= 16'h0000;
    end else if (done_out && we_in) begin
      if (be_in[1]) mem_r[idx][15:8] <= wdata_in[15:8];
      if (be_in[0]) mem_r[idx][7:0] <= wdata_in[7:0];
    end
  end
endmodule

/* tb/test_single_wire_debug_hw_commands.sv */
`timescale 1ns/1ps
`include "swd_params.svh"
module test_single_wire_debug_hw_commands;
  logic clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, fw_cmd_valid_in = 1'b0;
  logic fw_cmd_leave_in = 1'b0, special_mode_in = 1'b1, secured_in = 1'b0, ext_tag_in = 1'b0;
  logic erase_check_done_in = 1'b0, erase_ok_in = 1'b0, cpu_halt_to_debug_instr_in = 1'b0;
  logic bkpt_in = 1'b0, bkpt_after_next_in = 1'b0, cpu_instr_done_in = 1'b0, cpu_idle_in = 1'b1;
  logic [7:0] cmd_opcode_in = 8'h00;
  logic [15:0] cmd_addr_in = 16'h0000, cmd_wdata_in = 16'h0000, bus_rdata_in, rd_data_out;
  logic cmd_ready_out, rd_valid_out, ack_pulse_out, fw_cmd_exec_out, cpu_fw_start_out;
  logic cpu_resume_out, cpu_freeze_out, bus_cyc_out, bus_we_out, dbg_map_out, fw_area_map_out;
  logic debug_enable_flag_out, unsecure_flag_out, active_out, bus_done_in, hs = 1'b0;
  logic [15:0] bus_addr_out, bus_wdata_out, sh [0:127];
  logic [1:0] bus_be_out, lat = 2'h0;
  logic [31:0] seed = 32'd42820, note, rq [$];
  bit aq [$];
  bit idle_rand = 1'b1;
  int fail_count = 0, n_checks = 0, cyc = 0;

  always #20 clk_in = ~clk_in;
  swd_hwcmd i_swd_hwcmd (.*);
  swd_mem_model i_swd_mem_model (.clk_in(clk_in), .rst_in(rst_in), .cyc_in(bus_cyc_out),
    .map_in(dbg_map_out), .we_in(bus_we_out), .be_in(bus_be_out), .addr_in(bus_addr_out),
    .wdata_in(bus_wdata_out), .lat_in(lat), .rdata_out(bus_rdata_in), .done_out(bus_done_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic bad(input string s);
    fail_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic chk16(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) bad($sformatf("data %h, wanted %h", g, e));
  endtask
  task automatic chk1(input logic g, e);
    n_checks++;
    if (g !== e) bad($sformatf("flag %b, wanted %b", g, e));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // CPU activity, timeout and result watcher.
  always @(posedge clk_in) begin
    cyc++;
    cpu_instr_done_in <= cyc % 3 == 0;
    cpu_idle_in <= idle_rand && (rnd() & 32'h1) != 0;
    if (cyc > 20000) begin
      bad("timeout");
      end_of_test();
    end
  end
  always @(posedge clk_in) begin
    if (rd_valid_out === 1'b1) begin
      if (rq.size() == 0) bad("read data");
      else begin
        note = rq.pop_front();
        chk16(rd_data_out & note[31:16], note[15:0]);
      end
    end
    if (ack_pulse_out === 1'b1) begin
      if (aq.size() == 0) bad("handshake pulse");
      else void'(aq.pop_front());
    end
  end

  // ==========================================================================
  // Drivers.
  task automatic cmd(input logic [7:0] o, input logic [15:0] a, d);
    int n;
    @(posedge clk_in);
    {cmd_opcode_in, cmd_addr_in, cmd_wdata_in, cmd_valid_in} <= {o, a, d, 1'b1};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (cmd_ready_out !== 1'b1 && n < 300);
    cmd_valid_in <= 1'b0;
    if (n >= 300) bad("command not taken");
  endtask
  task automatic settle();
    int n;
    n = 0;
    while ((rq.size() + aq.size()) != 0 && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    repeat (6) @(posedge clk_in);
    chk1(rq.size() + aq.size() == 0, 1'b1);
  endtask
  task automatic wr(input logic dbg, w, input logic [15:0] a, d);
    if (w || !a[0]) sh[{dbg, a[6:1]}][15:8] = d[15:8];
    if (w || a[0]) sh[{dbg, a[6:1]}][7:0] = d[7:0];
    if (hs) aq.push_back(1'b1);
    cmd(8'hc0 | {4'h0, w, dbg, 2'h0}, a, d);
  endtask
  task automatic rd(input logic dbg, w, input logic [15:0] a);
    logic [15:0] v;
    v = sh[{dbg, a[6:1]}];
    rq.push_back({16'hffff, w ? v : a[0] ? {8'h00, v[7:0]} : {v[15:8], 8'h00}});
    if (hs) aq.push_back(1'b1);
    cmd(8'he0 | {4'h0, w, dbg, 2'h0}, a, 16'h0000);
  endtask
  task automatic rst(input logic sp, se);
    {special_mode_in, secured_in, rst_in, hs} <= {sp, se, 2'b10};
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (sh[i]) sh[i] = 16'h0000;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic flags(input logic en, act, un);
    chk1(debug_enable_flag_out, en);
    chk1(active_out, act);
    chk1(unsecure_flag_out, un);
  endtask
  task automatic fw(input logic e);
    @(posedge clk_in) fw_cmd_valid_in <= 1'b1;
    @(negedge clk_in) chk1(fw_cmd_exec_out, e);
    @(posedge clk_in) fw_cmd_valid_in <= 1'b0;
  endtask
  task automatic erase(input logic ok);
    @(posedge clk_in) {erase_check_done_in, erase_ok_in} <= {1'b1, ok};
    @(posedge clk_in) erase_check_done_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic hs_on();
    hs = 1'b1;
    aq.push_back(1'b1);
    cmd(`SWD_OP_ACK_ON, 16'h0000, 16'h0000);
  endtask

  // ==========================================================================
  // Scenarios.
  initial begin
    logic [31:0] r;
    rst(1'b1, 1'b0);
    flags(1'b1, 1'b1, 1'b0);
    hs_on();
    repeat (12) begin
      r = rnd();
      lat <= r[12:11];
      wr(r[7], r[8], {9'h000, r[6:0]}, r[31:16]);
      rd(r[7], r[9], {9'h000, r[6:1], r[10]});
    end
    settle();
    rq.push_back({16'h00ff, 16'h00c0});
    aq.push_back(1'b1);
    cmd(`SWD_OP_RD_BD_WORD, 16'hff00, 16'h0000);
    idle_rand = 1'b0;
    rd(1'b0, 1'b1, 16'h0004);
    settle();
    idle_rand = 1'b1;
    hs = 1'b0;
    cmd(`SWD_OP_ACK_OFF, 16'h0000, 16'h0000);
    wr(1'b0, 1'b1, 16'h0002, 16'h1234);
    rd(1'b0, 1'b0, 16'h0003);
    cmd(8'h00, 16'h0002, 16'hffff);
    rd(1'b0, 1'b1, 16'h0002);
    settle();
    fw_cmd_leave_in <= 1'b1;
    fw(1'b1);
    fw_cmd_leave_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    flags(1'b1, 1'b0, 1'b0);
    hs_on();
    aq.push_back(1'b1);
    cmd(`SWD_OP_HALT, 16'h0000, 16'h0000);
    settle();
    flags(1'b1, 1'b1, 1'b0);
    rst(1'b0, 1'b0);
    flags(1'b0, 1'b0, 1'b0);
    hs_on();
    cmd(`SWD_OP_HALT, 16'h0000, 16'h0000);
    @(posedge clk_in) cpu_halt_to_debug_instr_in <= 1'b1;
    @(posedge clk_in) cpu_halt_to_debug_instr_in <= 1'b0;
    settle();
    flags(1'b0, 1'b0, 1'b0);
    wr(1'b1, 1'b0, `SWD_STATUS_ADDR, 16'h0080);
    settle();
    flags(1'b1, 1'b0, 1'b0);
    @(posedge clk_in) ext_tag_in <= 1'b1;
    @(posedge clk_in) ext_tag_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    flags(1'b1, 1'b1, 1'b0);
    fw_cmd_leave_in <= 1'b1;
    fw(1'b1);
    fw_cmd_leave_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    flags(1'b1, 1'b0, 1'b0);
    @(posedge clk_in) {bkpt_in, bkpt_after_next_in} <= 2'b11;
    @(posedge clk_in) {bkpt_in, bkpt_after_next_in} <= 2'b00;
    repeat (12) @(posedge clk_in);
    flags(1'b1, 1'b1, 1'b0);
    rst(1'b0, 1'b1);
    cmd(`SWD_OP_ACK_ON, 16'h0000, 16'h0000);
    cmd(`SWD_OP_RD_WORD, 16'h0000, 16'h0000);
    settle();
    rst(1'b1, 1'b1);
    erase(1'b0);
    flags(1'b1, 1'b1, 1'b0);
    fw(1'b0);
    rd(1'b0, 1'b1, 16'h0008);
    settle();
    rst(1'b1, 1'b1);
    erase(1'b1);
    flags(1'b1, 1'b1, 1'b1);
    fw(1'b1);
    end_of_test();
  end
endmodule
